/* verilog/lar_routing_regs.sv */
// left record-channel input routing registers and their decoded controls
`timescale 1ns/1ps
// Behaviour
// - first line input: bit 7 selects single-ended 0 or differential 1; reset 0
// - second line input: bit 7 selects single-ended or differential; reset 0
// - level codes 0 to 8 give 0 to -12 dB in 1.5 dB steps
// - any gain code connects first input to mixer; 1111 disconnects, reset
// - any gain code connects second input to mixer; 1111 disconnects, reset
// - first register bit 2 powers the left channel up; reset down
// - bits 1-0: step every sample, every two samples, or none; reset 00
// - second register bit 2 weakly biases unselected inputs; reset off
// - second register bits 1-0 read 00; host writes zeros there
// - seven-bit gain, 0.5 dB per code, saturating at 59.5 dB; mute resets on
module lar_routing_regs
    import lar_pkg::*;
#(
    parameter int ADDR_W = 7
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    // register port from the control-bus front end, same clock
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // sample-rate timebase and amplifier gain register fields
    input wire logic fs_tick_i,
    input wire logic [6:0] pga_gain_i,
    input wire logic pga_mute_i,
    // analog controls
    output logic line_one_diff_o,
    output logic line_two_diff_o,
    output logic line_one_conn_o,
    output logic line_two_conn_o,
    output logic [4:0] line_one_atten_o,
    output logic [4:0] line_two_atten_o,
    output logic power_up_o,
    output logic cm_bias_o,
    output logic [1:0] step_sel_o,
    output logic [6:0] pga_gain_o,
    output logic pga_mute_o
);
    // offsets are seven bits wide
    if (ADDR_W != 7) begin : g_chk
        $error("lar_routing_regs: ADDR_W must be 7");
    end

    typedef struct packed {
        logic one_diff;
        logic [3:0] one_lvl;
        logic one_pwr;
        logic [1:0] one_step;
        logic two_diff;
        logic [3:0] two_lvl;
        logic two_bias;
        logic one_conn;
        logic two_conn;
        logic [4:0] one_atten;
        logic [4:0] two_atten;
        logic [7:0] rdata;
    } lar_reg_st_t;

    lar_reg_st_t st;
    lar_reg_st_t next_st;
    logic hit_one;
    logic hit_two;
    logic [3:0] wr_lvl;

    // code to half-dB attenuation; disconnect codes report zero
    function automatic logic [4:0] lvl_to_atten(input logic [3:0] lvl);
        logic [4:0] a;
        a = LAR_ATTEN_OFF_HDB;
        if (lvl <= LAR_LVL_LAST_GAIN) begin
            a = 5'({1'h0, lvl} * LAR_ATTEN_STEP_HDB);
        end
        return a;
    endfunction

    assign hit_one = (addr_i == LAR_OFF_LINE_ONE);
    assign hit_two = (addr_i == LAR_OFF_LINE_TWO);
    assign wr_lvl = wdata_i[LAR_LVL_HI:LAR_LVL_LO];

    // register writes, derived controls and the read mux
    always_comb begin
        next_st = st;
        if (wr_en_i && hit_one) begin
            next_st.one_diff = wdata_i[LAR_DIFF_BIT];
            next_st.one_lvl = wr_lvl;
            // reserved codes are treated as disconnected
            next_st.one_conn = (wr_lvl <= LAR_LVL_LAST_GAIN);
            next_st.one_atten = lvl_to_atten(wr_lvl);
            next_st.one_pwr = wdata_i[LAR_PWR_BIT];
            next_st.one_step = wdata_i[LAR_STEP_HI:LAR_STEP_LO];
        end
        if (wr_en_i && hit_two) begin
            next_st.two_diff = wdata_i[LAR_DIFF_BIT];
            next_st.two_lvl = wr_lvl;
            next_st.two_conn = (wr_lvl <= LAR_LVL_LAST_GAIN);
            next_st.two_atten = lvl_to_atten(wr_lvl);
            next_st.two_bias = wdata_i[LAR_BIAS_BIT];
            // bits 1-0 are not stored: written ones are dropped
        end
        // read data holds until the next read; unmapped reads give zero
        if (rd_en_i) begin
            next_st.rdata = LAR_RDATA_RST;
            if (hit_one) begin
                next_st.rdata = {st.one_diff, st.one_lvl, st.one_pwr,
                                 st.one_step};
            end else if (hit_two) begin
                next_st.rdata = {st.two_diff, st.two_lvl, st.two_bias,
                                 LAR_RSVD_RD};
            end
        end
    end

    // inputs start disconnected, channel down, stepping every sample
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{one_diff: LAR_DIFF_RST, one_lvl: LAR_LVL_RST,
                    one_pwr: LAR_PWR_RST, one_step: LAR_STEP_RST,
                    two_diff: LAR_DIFF_RST, two_lvl: LAR_LVL_RST,
                    two_bias: LAR_BIAS_RST, one_conn: 1'h0,
                    two_conn: 1'h0, one_atten: LAR_ATTEN_OFF_HDB,
                    two_atten: LAR_ATTEN_OFF_HDB,
                    rdata: LAR_RDATA_RST};
        end else begin
            st <= next_st;
        end
    end

    // the mode bits go out unchecked; left and right agreement is
    // software's job, nothing here sees the right channel
    assign line_one_diff_o = st.one_diff;
    assign line_two_diff_o = st.two_diff;
    assign line_one_conn_o = st.one_conn;
    assign line_two_conn_o = st.two_conn;
    assign line_one_atten_o = st.one_atten;
    assign line_two_atten_o = st.two_atten;
    assign power_up_o = st.one_pwr;
    assign cm_bias_o = st.two_bias;
    assign step_sel_o = st.one_step;
    assign rdata_o = st.rdata;

    // gain stepping paced by the sample timebase
    lar_gain_stepper #(
        .GAIN_W(7)
    ) lar_gain_stepper_inst (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .fs_tick_i(fs_tick_i),
        .step_sel_i(st.one_step),
        .target_i(pga_gain_i),
        .mute_i(pga_mute_i),
        .gain_o(pga_gain_o),
        .mute_o(pga_mute_o)
    );

    sequence s_wr_one;
        wr_en_i && hit_one;
    endsequence
    sequence s_wr_two;
        wr_en_i && hit_two;
    endsequence
    sequence s_rd_two;
        rd_en_i && hit_two;
    endsequence

    a_diff_one: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_one |=> line_one_diff_o == $past(wdata_i[LAR_DIFF_BIT]))
        else $error("first input mode not taken");
    a_diff_two: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_two |=> line_two_diff_o == $past(wdata_i[LAR_DIFF_BIT]))
        else $error("second input mode not taken");
    a_conn_one: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_one |=> line_one_conn_o == ($past(wr_lvl) <= LAR_LVL_LAST_GAIN))
        else $error("first input connection wrong");
    a_conn_two: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_two |=> line_two_conn_o == ($past(wr_lvl) <= LAR_LVL_LAST_GAIN))
        else $error("second input connection wrong");
    a_atten_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_one ##1 line_one_conn_o |->
        line_one_atten_o == 5'({1'h0, $past(wr_lvl)} * LAR_ATTEN_STEP_HDB))
        else $error("attenuation map wrong");
    a_power_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_one |=> power_up_o == $past(wdata_i[LAR_PWR_BIT]))
        else $error("power bit not taken");
    a_bias_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_two |=> cm_bias_o == $past(wdata_i[LAR_BIAS_BIT]))
        else $error("bias bit not taken");
    a_rsvd_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_rd_two |=> rdata_o[1:0] == LAR_RSVD_RD &&
        rdata_o[LAR_BIAS_BIT] == $past(cm_bias_o))
        else $error("reserved bits read nonzero");
    a_step_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_wr_one |=> step_sel_o == $past(wdata_i[LAR_STEP_HI:LAR_STEP_LO]))
        else $error("stepping field not taken");
endmodule // lar_routing_regs

/* include/lar_pkg.sv */
// constants for the left record-channel input routing registers
package lar_pkg;
    // register offsets on the control port
    localparam logic [6:0] LAR_OFF_LINE_ONE = 7'h13;
    localparam logic [6:0] LAR_OFF_LINE_TWO = 7'h14;
    // field positions, shared by both registers where they coincide
    localparam int LAR_DIFF_BIT = 7;
    localparam int LAR_LVL_HI = 6;
    localparam int LAR_LVL_LO = 3;
    localparam int LAR_PWR_BIT = 2;
    localparam int LAR_BIAS_BIT = 2;
    localparam int LAR_STEP_HI = 1;
    localparam int LAR_STEP_LO = 0;
    // reset values
    localparam logic LAR_DIFF_RST = 1'h0;
    localparam logic [3:0] LAR_LVL_RST = 4'hf;
    localparam logic LAR_PWR_RST = 1'h0;
    localparam logic [1:0] LAR_STEP_RST = 2'h0;
    localparam logic LAR_BIAS_RST = 1'h0;
    localparam logic [1:0] LAR_RSVD_RD = 2'h0;
    // level code map: 0..8 are gains, 15 disconnects
    localparam logic [3:0] LAR_LVL_LAST_GAIN = 4'h8;
    localparam logic [4:0] LAR_ATTEN_STEP_HDB = 5'h03;
    localparam logic [4:0] LAR_ATTEN_OFF_HDB = 5'h00;
    // soft-stepping selections
    localparam logic [1:0] LAR_STEP_EVERY = 2'h0;
    localparam logic [1:0] LAR_STEP_EVERY2 = 2'h1;
    // amplifier gain: 0.5 dB per code, saturating at 59.5 dB
    localparam logic [6:0] LAR_GAIN_MAX = 7'h77;
    localparam logic [6:0] LAR_GAIN_RST = 7'h00;
    localparam logic LAR_MUTE_RST = 1'h1;
    localparam logic [7:0] LAR_RDATA_RST = 8'h00;
endpackage

/* verilog/lar_gain_stepper.sv */
// amplifier gain soft-stepping toward the programmed target
`timescale 1ns/1ps
module lar_gain_stepper
    import lar_pkg::*;
#(
    parameter int GAIN_W = 7
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic fs_tick_i,
    input wire logic [1:0] step_sel_i,
    input wire logic [GAIN_W-1:0] target_i,
    input wire logic mute_i,
    output logic [GAIN_W-1:0] gain_o,
    output logic mute_o
);
    // the saturation constant is seven bits wide
    if (GAIN_W != 7) begin : g_chk
        $error("lar_gain_stepper: GAIN_W must be 7");
    end

    typedef struct packed {
        logic half;
        logic [GAIN_W-1:0] gain;
        logic mute;
    } lar_step_st_t;

    lar_step_st_t st;
    lar_step_st_t next_st;
    logic [GAIN_W-1:0] tgt;
    logic stepping;
    logic step_now;

    // codes above the top value all mean 59.5 dB
    assign tgt = (target_i >= LAR_GAIN_MAX) ? LAR_GAIN_MAX : target_i;
    assign stepping = (step_sel_i == LAR_STEP_EVERY) ||
                      (step_sel_i == LAR_STEP_EVERY2);
    assign step_now = fs_tick_i &&
        ((step_sel_i == LAR_STEP_EVERY) || st.half);

    // one code per interval, or jump when stepping is off
    always_comb begin
        next_st = st;
        next_st.mute = mute_i;
        if (fs_tick_i) begin
            next_st.half = ~st.half;
        end
        if (!stepping) begin
            next_st.gain = tgt;
        end else if (step_now && st.gain < tgt) begin
            next_st.gain = st.gain + 7'h01;
        end else if (step_now && st.gain > tgt) begin
            next_st.gain = st.gain - 7'h01;
        end
    end

    // mute resets set, so the amplifier starts silent
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '{half: 1'h0, gain: LAR_GAIN_RST, mute: LAR_MUTE_RST};
        end else begin
            st <= next_st;
        end
    end

    assign gain_o = st.gain;
    assign mute_o = st.mute;

    sequence s_step_every;
        step_sel_i == LAR_STEP_EVERY && fs_tick_i && gain_o < tgt;
    endsequence

    a_step_up_one: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_step_every |=> gain_o == $past(gain_o) + 7'h01)
        else $error("gain did not rise one code");
    a_step_jump: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !stepping ##1 !stepping |-> gain_o == $past(tgt))
        else $error("disabled stepping did not jump");
    a_step_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        stepping && !fs_tick_i |=> $stable(gain_o))
        else $error("gain moved without a sample tick");
    a_gain_sat: assert property (@(posedge clk_i) disable iff (!rstn_i)
        gain_o <= LAR_GAIN_MAX)
        else $error("applied gain above 59.5 dB");
    a_half_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        step_sel_i == LAR_STEP_EVERY2 && fs_tick_i && !st.half |=>
        $stable(gain_o))
        else $error("half-rate stepping moved early");
endmodule // lar_gain_stepper

/* sim/test_lar_routing_regs.sv */
// self-checking bench for the left record-channel routing registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_lar_routing_regs
    import lar_pkg::*;
;
    logic clk_i, rstn_i = 1'h0, wr_en_i = 1'h0, rd_en_i = 1'h0, pga_mute_o;
    logic fs_tick_i = 1'h0, pga_mute_i = 1'h1, power_up_o, cm_bias_o;
    logic line_one_diff_o, line_two_diff_o, line_one_conn_o, line_two_conn_o;
    logic [6:0] addr_i = 7'h00, pga_gain_i = 7'h00, pga_gain_o;
    logic [7:0] wdata_i = 8'h00, rdata_o, rd_val;
    logic [4:0] line_one_atten_o, line_two_atten_o;
    logic [1:0] step_sel_o;
    int bad_count, check_count, cycles;
    lar_routing_regs lar_routing_regs_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .fs_tick_i(fs_tick_i),
        .pga_gain_i(pga_gain_i), .pga_mute_i(pga_mute_i),
        .line_one_diff_o(line_one_diff_o), .line_two_diff_o(line_two_diff_o),
        .line_one_conn_o(line_one_conn_o), .line_two_conn_o(line_two_conn_o),
        .line_one_atten_o(line_one_atten_o),
        .line_two_atten_o(line_two_atten_o), .power_up_o(power_up_o),
        .cm_bias_o(cm_bias_o), .step_sel_o(step_sel_o),
        .pga_gain_o(pga_gain_o), .pga_mute_o(pga_mute_o));
    // 250 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    // a hang ends the run well after the ~100 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one-cycle strobe starting one edge on; read data stands after it
    task automatic bus(input logic w, logic [6:0] a, logic [7:0] d);
        idle(1);
        wr_en_i = w;
        rd_en_i = !w;
        addr_i = a;
        wdata_i = d;
        idle(1);
        wr_en_i = 1'h0;
        rd_en_i = 1'h0;
        rd_val = rdata_o;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            idle(1);
            fs_tick_i = 1'h1;
            idle(1);
            fs_tick_i = 1'h0;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic do_reset;
        idle(1);
        rstn_i = 1'h0;
        idle(2);
        rstn_i = 1'h1;
    endtask
    task automatic t_reset_values;
        `CHK("diff one", 1'h0, line_one_diff_o)
        `CHK("diff two", 1'h0, line_two_diff_o)
        `CHK("conn one", 1'h0, line_one_conn_o)
        `CHK("conn two", 1'h0, line_two_conn_o)
        `CHK("power", 1'h0, power_up_o)
        `CHK("step", 2'h0, step_sel_o)
        `CHK("bias", 1'h0, cm_bias_o)
        `CHK("mute", 1'h1, pga_mute_o)
        `CHK("gain", 7'h00, pga_gain_o)
        bus(1'h0, LAR_OFF_LINE_ONE, 8'h00);
        `CHK("reg one", 8'h78, rd_val)
        bus(1'h0, LAR_OFF_LINE_TWO, 8'h00);
        `CHK("reg two", 8'h78, rd_val)
    endtask
    // every gain code and the disconnect code; reserved ones never sent
    task automatic t_levels;
        for (int c = 0; c < 10; c++) begin
            bus(1'h1, LAR_OFF_LINE_ONE, {1'h0, c == 9 ? 4'hf : 4'(c), 3'h0});
            bus(1'h1, LAR_OFF_LINE_TWO, {1'h0, c == 9 ? 4'hf : 4'(c), 3'h0});
            `CHK("conn one", 1'(c < 9), line_one_conn_o)
            `CHK("atten one", 5'(c < 9 ? c * 3 : 0), line_one_atten_o)
            `CHK("conn two", 1'(c < 9), line_two_conn_o)
            `CHK("atten two", 5'(c < 9 ? c * 3 : 0), line_two_atten_o)
        end
    endtask
    task automatic t_fields;
        bus(1'h1, LAR_OFF_LINE_ONE, 8'h86); // host mirrors right mode
        `CHK("diff one", 1'h1, line_one_diff_o)
        `CHK("power", 1'h1, power_up_o)
        `CHK("step", 2'h2, step_sel_o)
        `CHK("diff two", 1'h0, line_two_diff_o)
        bus(1'h0, LAR_OFF_LINE_ONE, 8'h00);
        `CHK("reg one", 8'h86, rd_val)
        bus(1'h1, LAR_OFF_LINE_TWO, 8'h84); // read-only pair kept zero
        `CHK("diff two", 1'h1, line_two_diff_o)
        `CHK("bias", 1'h1, cm_bias_o)
        `CHK("diff one", 1'h1, line_one_diff_o)
        bus(1'h0, LAR_OFF_LINE_TWO, 8'h00);
        `CHK("reg two", 8'h84, rd_val)
        bus(1'h1, 7'h15, 8'hff); // unmapped: both registers left alone
        bus(1'h0, 7'h15, 8'h00);
        `CHK("unmapped", 8'h00, rd_val)
        `CHK("bias", 1'h1, cm_bias_o)
        `CHK("step", 2'h2, step_sel_o)
    endtask
    // phase-free checks: of any two ticks under 01 exactly one steps
    task automatic t_stepping;
        do_reset();
        pga_gain_i = 7'h02;
        idle(2);
        `CHK("gain hold", 7'h00, pga_gain_o)
        tick(1);
        `CHK("gain step", 7'h01, pga_gain_o)
        tick(1);
        `CHK("gain step", 7'h02, pga_gain_o)
        bus(1'h1, LAR_OFF_LINE_ONE, 8'h01);
        pga_gain_i = 7'h04;
        tick(2);
        `CHK("gain half", 7'h03, pga_gain_o)
        tick(2);
        `CHK("gain half", 7'h04, pga_gain_o)
        pga_gain_i = 7'h03;
        tick(2);
        `CHK("gain down", 7'h03, pga_gain_o)
        bus(1'h1, LAR_OFF_LINE_ONE, 8'h03);
        pga_gain_i = 7'h7f;
        pga_mute_i = 1'h0;
        idle(2);
        `CHK("gain sat", 7'h77, pga_gain_o)
        `CHK("mute", 1'h0, pga_mute_o)
    endtask
    initial begin
        idle(2);
        rstn_i = 1'h1;
        t_reset_values();
        t_levels();
        t_fields();
        t_stepping();
        // second reset in mid-run must restore every default
        bus(1'h1, LAR_OFF_LINE_TWO, 8'h84);
        do_reset();
        t_reset_values();
        wrap_up();
    end
endmodule // test_lar_routing_regs
